// ### rtl/motion_start_pkg.sv
package motion_start_pkg;
   // sizes
   localparam int          N_AXES       = 4;
   localparam int          AX_W         = 2;
   localparam int          DATA_W       = 32;
   localparam int          ADDR_W       = 8;
   localparam int          CODE_W       = 9;
   localparam int          POS_W        = 16;

   // register byte addresses
   localparam logic [7:0]  ADDR_CMD     = 8'h00;
   localparam logic [7:0]  ADDR_STEPS   = 8'h04;
   localparam logic [7:0]  ADDR_INTERP  = 8'h08;
   localparam logic [7:0]  ADDR_SPEED   = 8'h0c;
   localparam logic [7:0]  ADDR_LIMIT   = 8'h10;
   localparam logic [7:0]  ADDR_ARC     = 8'h14;
   localparam logic [7:0]  ADDR_SEG1_X  = 8'h18;
   localparam logic [7:0]  ADDR_SEG1_Y  = 8'h1c;
   localparam logic [7:0]  ADDR_SEG2_X  = 8'h20;
   localparam logic [7:0]  ADDR_SEG2_Y  = 8'h24;
   localparam logic [7:0]  ADDR_AXCFG   = 8'h28;
   localparam logic [7:0]  ADDR_STATE   = 8'h2c;
   localparam logic [7:0]  ADDR_IRQ_ST  = 8'h30;
   localparam logic [7:0]  ADDR_IRQ_MSK = 8'h34;
   localparam logic [7:0]  ADDR_ERR0    = 8'h38;

   // command register fields
   localparam int          CMD_OP_LSB   = 0;
   localparam int          CMD_AX_LSB   = 4;
   localparam int          CMD_CONT_BIT = 6;
   localparam logic [2:0]  OP_POINT     = 3'h1;
   localparam logic [2:0]  OP_INDIRECT  = 3'h2;
   localparam logic [2:0]  OP_LINEAR    = 3'h3;
   localparam logic [2:0]  OP_AUX_CLR   = 3'h4;
   localparam logic [2:0]  OP_FLOAT_ORG = 3'h5;

   // interpolation setup fields
   localparam int          IP_MAIN_LSB  = 0;
   localparam int          IP_SUB_LSB   = 2;
   localparam int          IP_MAIN_EN   = 4;
   localparam int          IP_SUB_EN    = 5;
   localparam int          IP_ABS       = 6;
   localparam int          IP_CONT      = 7;

   // interrupt status bits
   localparam int          EV_REFUSED   = 0;
   localparam int          EV_STARTED   = 1;
   localparam int          EV_AUX_ON    = 2;
   localparam int          N_EVENTS     = 3;

   // limits and error codes
   localparam logic [7:0]  MAX_STEPS    = 8'h14;
   localparam logic [15:0] ARC_OFF      = 16'h0000;
   localparam logic [8:0]  ERR_NONE     = 9'h000;
   localparam logic [8:0]  ERR_STEPS    = 9'h0ed;
   localparam logic [8:0]  ERR_SCURVE   = 9'h0ee;
   localparam logic [8:0]  ERR_BUSY_M   = 9'h0f1;
   localparam logic [8:0]  ERR_BUSY_S   = 9'h0f2;
   localparam logic [8:0]  ERR_AUX_M    = 9'h0f7;
   localparam logic [8:0]  ERR_AUX_S    = 9'h0f8;
   localparam logic [8:0]  ERR_ORG_M    = 9'h0fa;
   localparam logic [8:0]  ERR_ORG_S    = 9'h0fb;
   localparam logic [8:0]  ERR_ASSIGN   = 9'h0fd;
   localparam logic [8:0]  ERR_RDY_M    = 9'h0fe;
   localparam logic [8:0]  ERR_RDY_S    = 9'h0ff;
   localparam logic [8:0]  ERR_SPEED    = 9'h105;
   localparam logic [8:0]  ERR_ARC_LONG = 9'h106;
   localparam logic [8:0]  ERR_ARC_SAME = 9'h107;
endpackage : motion_start_pkg

// ### rtl/motion_start_precondition_checker.sv
// Functional notes
// - point start with more than 20 steps is refused with code 237.
// - indirect continuous start on an S-curve axis is refused with code 238.
// - linear start refused with 241 while main axis is moving.
// - linear start refused with 242 while subordinate axis is moving.
// - linear start refused with 247 while main axis aux code is on.
// - linear start refused with 248 while subordinate aux code is on.
// - aux code clear command drops that axis's aux code output.
// - absolute linear move refused with 250 if main axis origin undetermined.
// - absolute linear move refused with 251 if subordinate origin undetermined.
// - origin becomes determined only by homing done or floating origin command.
// - linear start refused with 253 when axis assignment is incomplete.
// - linear start refused with 254 when main drive ready is low.
// - linear start refused with 255 when subordinate drive ready is low.
// - linear start refused with 261 when main speed exceeds speed limit.
// - corner arc refused with 262 when insertion exceeds a segment length.
// - corner arc refused with 263 when both segments end at same position.
// - arc insertion setting zero means no arc and no geometry checks.
//
// Implementation choices: the plain strobed port and the placing of the registers.
module motion_start_precondition_checker
   import motion_start_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [DATA_W-1:0]   wr_data,
   input  wire logic                wr_en,
   input  wire logic                rd_en,
   output logic      [DATA_W-1:0]   rd_data_r,
   input  wire logic [N_AXES-1:0]   drive_ready,
   input  wire logic [N_AXES-1:0]   axis_busy,
   input  wire logic [N_AXES-1:0]   homing_done,
   input  wire logic [N_AXES-1:0]   aux_code_set,
   output logic      [N_AXES-1:0]   axis_start_r,
   output logic      [N_AXES-1:0]   aux_code_r,
   output logic                     arc_insert_r,
   output logic                     irq_r
);

   // software setup registers and internal state latches
   logic [7:0]          steps_r;
   logic [7:0]          interp_r;
   logic [15:0]         speed_r;
   logic [15:0]         limit_r;
   logic [15:0]         arc_r;
   logic [POS_W-1:0]    seg1_x_r;
   logic [POS_W-1:0]    seg1_y_r;
   logic [POS_W-1:0]    seg2_x_r;
   logic [POS_W-1:0]    seg2_y_r;
   logic [N_AXES-1:0]   scurve_r;
   logic [N_EVENTS-1:0] irq_st_r;
   logic [N_EVENTS-1:0] irq_msk_r;
   logic [N_EVENTS-1:0] ev_nxt;
   logic [N_AXES-1:0]   origin_r;
   logic [CODE_W-1:0]   err_r [N_AXES];
   logic [N_AXES-1:0]   rdy_meta_r;
   logic [N_AXES-1:0]   rdy_r;

   // decoded command
   // combinational, valid only in the cycle of a command write
   logic                cmd_wr;
   logic [2:0]          op;
   logic [AX_W-1:0]     cmd_ax;
   logic                cmd_cont;
   logic [AX_W-1:0]     main_ax;
   logic [AX_W-1:0]     sub_ax;
   logic                main_en;
   logic                sub_en;
   logic                abs_mode;
   logic                cont_mode;
   logic                arc_chk;
   logic                arc_long;
   logic                arc_same;
   logic [POS_W-1:0]    len1;
   logic [POS_W-1:0]    len2;
   logic [CODE_W-1:0]   code_nxt;
   logic [AX_W-1:0]     err_ax;
   logic                is_start;
   logic [N_AXES-1:0]   start_nxt;
   logic [N_AXES-1:0]   aux_clr;
   logic [N_AXES-1:0]   org_float;

   // magnitude of a signed segment component
   // two's complement negate, so the most negative value stays as is
   function automatic logic [POS_W-1:0] mag(input logic [POS_W-1:0] v);
      logic [POS_W-1:0] r;
      r = v[POS_W-1] ? (~v + 16'h0001) : v;
      return r;
   endfunction : mag

   // longer of the two components stands for the segment length
   // a cheap stand-in for the true length, no multiplier needed
   function automatic logic [POS_W-1:0] seg_len(input logic [POS_W-1:0] x, input logic [POS_W-1:0] y);
      logic [POS_W-1:0] ax;
      logic [POS_W-1:0] ay;
      ax = mag(x);
      ay = mag(y);
      return (ax > ay) ? ax : ay;
   endfunction : seg_len

   // command strobe and field decode of the command and interpolation registers
   assign cmd_wr    = wr_en && (addr == ADDR_CMD);
   assign op        = wr_data[CMD_OP_LSB +: 3];
   assign cmd_ax    = wr_data[CMD_AX_LSB +: AX_W];
   assign cmd_cont  = wr_data[CMD_CONT_BIT];
   assign main_ax   = interp_r[IP_MAIN_LSB +: AX_W];
   assign sub_ax    = interp_r[IP_SUB_LSB +: AX_W];
   assign main_en   = interp_r[IP_MAIN_EN];
   assign sub_en    = interp_r[IP_SUB_EN];
   assign abs_mode  = interp_r[IP_ABS];
   assign cont_mode = interp_r[IP_CONT];
   assign len1      = seg_len(seg1_x_r, seg1_y_r);
   assign len2      = seg_len(seg2_x_r, seg2_y_r);

   // arc geometry only matters for continuous moves with a nonzero setting
   // a zero setting masks both arc refusals as well as the arc flag
   assign arc_chk  = cont_mode && (arc_r != ARC_OFF);
   assign arc_long = (arc_r > len1) || (arc_r > len2);
   assign arc_same = (seg1_x_r == seg2_x_r) && (seg1_y_r == seg2_y_r);

   // two-stage synchroniser for the drive ready pins
   // the ready pins come from the drives, outside this clock domain
   // only the second stage feeds the checks, so a metastable bit never reaches them
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdy_meta_r <= '0;
         rdy_r      <= '0;
      end else begin
         rdy_meta_r <= drive_ready;
         rdy_r      <= rdy_meta_r;
      end
   end

   // precondition evaluation, checked in ascending code order
   // the first failing check wins, which gives the lowest code
   // it sees the state of the write cycle itself, so no linear start slips past a busy axis; point and indirect starts ignore busy
   always_comb begin
      code_nxt = ERR_NONE;
      err_ax   = cmd_ax;
      is_start = 1'b0;
      case (op)
         OP_POINT: begin
            is_start = 1'b1;
            if (steps_r > MAX_STEPS) begin
               code_nxt = ERR_STEPS;
            end
         end
         OP_INDIRECT: begin
            is_start = 1'b1;
            if (cmd_cont && scurve_r[cmd_ax]) begin
               code_nxt = ERR_SCURVE;
            end
         end
         OP_LINEAR: begin
            is_start = 1'b1;
            err_ax   = main_ax;
            if (main_en && axis_busy[main_ax]) begin
               code_nxt = ERR_BUSY_M;
            end else if (sub_en && axis_busy[sub_ax]) begin
               code_nxt = ERR_BUSY_S;
            end else if (main_en && aux_code_r[main_ax]) begin
               code_nxt = ERR_AUX_M;
            end else if (sub_en && aux_code_r[sub_ax]) begin
               code_nxt = ERR_AUX_S;
            end else if (main_en && abs_mode && !origin_r[main_ax]) begin
               code_nxt = ERR_ORG_M;
            end else if (sub_en && abs_mode && !origin_r[sub_ax]) begin
               code_nxt = ERR_ORG_S;
            end else if (!main_en || !sub_en || (main_ax == sub_ax)) begin
               code_nxt = ERR_ASSIGN;
            end else if (!rdy_r[main_ax]) begin
               code_nxt = ERR_RDY_M;
            end else if (!rdy_r[sub_ax]) begin
               code_nxt = ERR_RDY_S;
            end else if (speed_r > limit_r) begin
               code_nxt = ERR_SPEED;
            end else if (arc_chk && arc_long) begin
               code_nxt = ERR_ARC_LONG;
            end else if (arc_chk && arc_same) begin
               code_nxt = ERR_ARC_SAME;
            end
         end
         default: begin
            is_start = 1'b0;
         end
      endcase
   end

   // axes to launch when the command passes every check
   // a linear start launches both assigned axes together
   always_comb begin
      start_nxt = '0;
      aux_clr   = '0;
      org_float = '0;
      if (cmd_wr) begin
         if (is_start && (code_nxt == ERR_NONE)) begin
            if (op == OP_LINEAR) begin
               start_nxt[main_ax] = 1'b1;
               start_nxt[sub_ax]  = 1'b1;
            end else begin
               start_nxt[cmd_ax] = 1'b1;
            end
         end
         if (op == OP_AUX_CLR) begin
            aux_clr[cmd_ax] = 1'b1;
         end
         if (op == OP_FLOAT_ORG) begin
            org_float[cmd_ax] = 1'b1;
         end
      end
   end

   // one-cycle start pulses towards the pulse generators
   // one cycle only, so a pulse generator never sees a start twice
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         axis_start_r <= '0;
      end else begin
         axis_start_r <= start_nxt;
      end
   end

   // corner arc flag follows each accepted linear start
   // it holds until the next accepted linear start, refusals leave it alone
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         arc_insert_r <= 1'b0;
      end else if (cmd_wr && (op == OP_LINEAR) && (code_nxt == ERR_NONE)) begin
         arc_insert_r <= arc_chk;
      end
   end

   // aux code outputs: raised by the motion engine, dropped by clear command
   // an engine raise in the cycle of a clear wins, so a new code is never lost
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         aux_code_r <= '0;
      end else begin
         aux_code_r <= (aux_code_r & ~aux_clr) | aux_code_set;
      end
   end

   // origin determined only by homing completion or floating origin set
   // nothing but reset forgets an origin
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         origin_r <= '0;
      end else begin
         origin_r <= origin_r | homing_done | org_float;
      end
   end

   // per-axis error code latches, cleared by writing the register
   // a new refusal in the cycle of the clearing write wins over the clear
   genvar g;
   generate
      for (g = 0; g < N_AXES; g++) begin : g_err
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               err_r[g] <= ERR_NONE;
            end else if (cmd_wr && is_start && (code_nxt != ERR_NONE) && (err_ax == AX_W'(g))) begin
               err_r[g] <= code_nxt;
            end else if (wr_en && (addr == ADDR_ERR0 + 8'(4 * g))) begin
               err_r[g] <= ERR_NONE;
            end
         end
      end
   endgenerate

   // setup registers written by software
   // fields are narrower than the bus, upper write bits are dropped
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         steps_r   <= '0;
         interp_r  <= '0;
         speed_r   <= '0;
         limit_r   <= '0;
         arc_r     <= ARC_OFF;
         seg1_x_r  <= '0;
         seg1_y_r  <= '0;
         seg2_x_r  <= '0;
         seg2_y_r  <= '0;
         scurve_r  <= '0;
         irq_msk_r <= '0;
      end else if (wr_en) begin
         case (addr)
            ADDR_STEPS:   steps_r   <= wr_data[7:0];
            ADDR_INTERP:  interp_r  <= wr_data[7:0];
            ADDR_SPEED:   speed_r   <= wr_data[15:0];
            ADDR_LIMIT:   limit_r   <= wr_data[15:0];
            ADDR_ARC:     arc_r     <= wr_data[15:0];
            ADDR_SEG1_X:  seg1_x_r  <= wr_data[POS_W-1:0];
            ADDR_SEG1_Y:  seg1_y_r  <= wr_data[POS_W-1:0];
            ADDR_SEG2_X:  seg2_x_r  <= wr_data[POS_W-1:0];
            ADDR_SEG2_Y:  seg2_y_r  <= wr_data[POS_W-1:0];
            ADDR_AXCFG:   scurve_r  <= wr_data[N_AXES-1:0];
            ADDR_IRQ_MSK: irq_msk_r <= wr_data[N_EVENTS-1:0];
            default: begin
               steps_r <= steps_r;
            end
         endcase
      end
   end

   // interrupt events of this cycle
   // a raise on an axis whose code is already on is no new event
   always_comb begin
      ev_nxt             = '0;
      ev_nxt[EV_REFUSED] = cmd_wr && is_start && (code_nxt != ERR_NONE);
      ev_nxt[EV_STARTED] = |start_nxt;
      ev_nxt[EV_AUX_ON]  = |(aux_code_set & ~aux_code_r);
   end

   // sticky status, write one to clear, a new event wins over the clear
   // so software cannot lose an event that lands on its clearing write
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_st_r <= '0;
      end else begin
         if (wr_en && (addr == ADDR_IRQ_ST)) begin
            irq_st_r <= (irq_st_r & ~wr_data[N_EVENTS-1:0]) | ev_nxt;
         end else begin
            irq_st_r <= irq_st_r | ev_nxt;
         end
      end
   end

   // level interrupt, high while any unmasked status bit is set
   // registered, so it follows a status or mask change by one cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_st_r & irq_msk_r);
      end
   end

   // read port, data valid only in the cycle after the strobe
   // idle and unmapped cycles return zero, unused upper bits always read zero
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rd_data_r <= '0;
      end else if (rd_en) begin
         rd_data_r <= '0;
         case (addr)
            ADDR_STEPS:   rd_data_r[7:0]          <= steps_r;
            ADDR_INTERP:  rd_data_r[7:0]          <= interp_r;
            ADDR_SPEED:   rd_data_r[15:0]         <= speed_r;
            ADDR_LIMIT:   rd_data_r[15:0]         <= limit_r;
            ADDR_ARC:     rd_data_r[15:0]         <= arc_r;
            ADDR_SEG1_X:  rd_data_r[POS_W-1:0]    <= seg1_x_r;
            ADDR_SEG1_Y:  rd_data_r[POS_W-1:0]    <= seg1_y_r;
            ADDR_SEG2_X:  rd_data_r[POS_W-1:0]    <= seg2_x_r;
            ADDR_SEG2_Y:  rd_data_r[POS_W-1:0]    <= seg2_y_r;
            ADDR_AXCFG:   rd_data_r[N_AXES-1:0]   <= scurve_r;
            ADDR_STATE:   rd_data_r[15:0]         <= {rdy_r, origin_r, aux_code_r, axis_busy};
            ADDR_IRQ_ST:  rd_data_r[N_EVENTS-1:0] <= irq_st_r;
            ADDR_IRQ_MSK: rd_data_r[N_EVENTS-1:0] <= irq_msk_r;
            ADDR_ERR0:    rd_data_r[CODE_W-1:0]   <= err_r[0];
            ADDR_ERR0 + 8'h04: rd_data_r[CODE_W-1:0] <= err_r[1];
            ADDR_ERR0 + 8'h08: rd_data_r[CODE_W-1:0] <= err_r[2];
            ADDR_ERR0 + 8'h0c: rd_data_r[CODE_W-1:0] <= err_r[3];
            default: begin
               rd_data_r <= '0;
            end
         endcase
      end else begin
         rd_data_r <= '0;
      end
   end

endmodule : motion_start_precondition_checker

// ### testbench/axis_engine_model.sv
module axis_engine_model
   import motion_start_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic [N_AXES-1:0] axis_start_r,
   input  wire logic [N_AXES-1:0] rdy_cfg,
   input  wire logic [N_AXES-1:0] hold_cfg,
   input  wire logic [N_AXES-1:0] home_req,
   input  wire logic [N_AXES-1:0] aux_req,
   output logic      [N_AXES-1:0] drive_ready,
   output logic      [N_AXES-1:0] axis_busy,
   output logic      [N_AXES-1:0] homing_done,
   output logic      [N_AXES-1:0] aux_code_set
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [N_AXES-1:0] run_r;
   logic [2:0]        cnt_r;

   // a started axis moves for a few cycles, then goes idle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         run_r <= '0;
         cnt_r <= 3'h0;
      end else if (axis_start_r != '0) begin
         run_r <= run_r | axis_start_r;
         cnt_r <= 3'h4;
      end else if (cnt_r != 3'h0) begin
         cnt_r <= cnt_r - 3'h1;
      end else begin
         run_r <= '0;
      end
   end

   // held busy and the other pins follow the bench's knobs
   assign axis_busy    = run_r | hold_cfg;
   assign drive_ready  = rdy_cfg;
   assign homing_done  = home_req;
   assign aux_code_set = aux_req;
endmodule : axis_engine_model

// ### testbench/start_check_asserts.sv
module start_check_asserts
   import motion_start_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic              wr_en,
   input wire logic              rd_en,
   input wire logic [DATA_W-1:0] rd_data_r,
   input wire logic [N_AXES-1:0] drive_ready,
   input wire logic [N_AXES-1:0] axis_busy,
   input wire logic [N_AXES-1:0] homing_done,
   input wire logic [N_AXES-1:0] aux_code_set,
   input wire logic [N_AXES-1:0] axis_start_r,
   input wire logic [N_AXES-1:0] aux_code_r,
   input wire logic              arc_insert_r,
   input wire logic              irq_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // command write decode
   logic cmd;
   logic lin;
   logic clr;
   assign cmd = wr_en && addr == ADDR_CMD;
   assign lin = cmd && wr_data[2:0] == OP_LINEAR;
   assign clr = cmd && wr_data[2:0] == OP_AUX_CLR;

   chk_start_cause: assert property (
      axis_start_r != 4'h0 |-> $past(cmd)) else $error("start pulse without command");
   chk_point_axis: assert property (
      $past(cmd) && $past(wr_data[2:0]) == OP_POINT && axis_start_r != 4'h0
      |-> axis_start_r == 4'h1 << $past(wr_data[5:4])) else $error("point start on wrong axis");
   chk_busy_refuse: assert property (
      lin && axis_busy == 4'hf |=> axis_start_r == 4'h0) else $error("start while axes busy");
   chk_aux_refuse: assert property (
      lin && aux_code_r == 4'hf |=> axis_start_r == 4'h0) else $error("start while aux codes on");
   chk_ready_refuse: assert property (
      drive_ready == 4'h0 [*3] ##0 lin |=> axis_start_r == 4'h0) else $error("start with no drive ready");
   chk_aux_clear: assert property (
      clr && !aux_code_set[wr_data[5:4]] |=> !aux_code_r[$past(wr_data[5:4])]) else $error("aux code not cleared");
   chk_aux_hold: assert property (
      ($past(aux_code_r) & ~aux_code_r) != 4'h0 |-> $past(clr)) else $error("aux code dropped on its own");
   chk_aux_raise: assert property (
      aux_code_set != 4'h0 |=> (aux_code_r & $past(aux_code_set)) == $past(aux_code_set))
      else $error("aux code not raised");
   chk_read_quiet: assert property (
      rd_data_r != 32'h0 |-> $past(rd_en)) else $error("read data outside read slot");
endmodule : start_check_asserts

bind motion_start_precondition_checker start_check_asserts start_check_asserts_i (
   .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data_r(rd_data_r), .drive_ready(drive_ready), .axis_busy(axis_busy), .homing_done(homing_done),
   .aux_code_set(aux_code_set), .axis_start_r(axis_start_r), .aux_code_r(aux_code_r),
   .arc_insert_r(arc_insert_r), .irq_r(irq_r));

// ### testbench/tb_top.sv
module tb_top
   import motion_start_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              sys_clk, rst_n, wr_en, rd_en, arc_insert_r, irq_r;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data, rd_data_r;
   logic [N_AXES-1:0] drive_ready, axis_busy, homing_done, aux_code_set, axis_start_r, aux_code_r;
   logic [N_AXES-1:0] rdy_cfg, hold_cfg, home_req, aux_req;
   int                n_mismatch = 0;
   int                num_checks = 0;
   int                cyc = 0;

   motion_start_precondition_checker motion_start_precondition_checker_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data_r(rd_data_r), .drive_ready(drive_ready), .axis_busy(axis_busy), .homing_done(homing_done),
      .aux_code_set(aux_code_set), .axis_start_r(axis_start_r), .aux_code_r(aux_code_r),
      .arc_insert_r(arc_insert_r), .irq_r(irq_r));
   axis_engine_model axis_engine_model_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .axis_start_r(axis_start_r), .rdy_cfg(rdy_cfg),
      .hold_cfg(hold_cfg), .home_req(home_req), .aux_req(aux_req), .drive_ready(drive_ready),
      .axis_busy(axis_busy), .homing_done(homing_done), .aux_code_set(aux_code_set));

   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // one-cycle strobes, launched and dropped at rising edges
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(logic [7:0] a, logic [31:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 check("read", rd_data_r, exp);
   endtask : rd

   function automatic logic [31:0] cw(logic [2:0] op, logic [1:0] ax, logic cont);
      return {25'h0, cont, ax, 1'b0, op};
   endfunction : cw

   // linear start of axes 0 and 1, then error readback and clear
   task automatic lin(logic [7:0] ip, logic [8:0] code, logic arc);
      wr(ADDR_INTERP, {24'h0, ip});
      wr(ADDR_CMD, cw(OP_LINEAR, 2'h0, 1'b0));
      #1 check("start", axis_start_r, (code == ERR_NONE) ? 4'h3 : 4'h0);
      if (code == ERR_NONE) check("arc", arc_insert_r, arc);
      rd(ADDR_ERR0, {23'h0, code});
      wr(ADDR_ERR0, 32'h0);
      repeat (10) @(posedge sys_clk);
   endtask : lin

   task automatic t_point;
      rd(ADDR_CMD, 32'h0);
      rd(8'h80, 32'h0);
      wr(ADDR_STEPS, 32'h15);
      wr(ADDR_CMD, cw(OP_POINT, 2'h1, 1'b0));
      #1 check("start", axis_start_r, 4'h0);
      rd(ADDR_ERR0 + 8'h4, {23'h0, ERR_STEPS});
      wr(ADDR_STEPS, 32'h14);
      wr(ADDR_CMD, cw(OP_POINT, 2'h1, 1'b0));
      #1 check("start", axis_start_r, 4'h2);
      wr(ADDR_AXCFG, 32'h4);
      wr(ADDR_CMD, cw(OP_INDIRECT, 2'h2, 1'b1));
      #1 check("start", axis_start_r, 4'h0);
      rd(ADDR_ERR0 + 8'h8, {23'h0, ERR_SCURVE});
      wr(ADDR_CMD, cw(OP_INDIRECT, 2'h2, 1'b0));
      #1 check("start", axis_start_r, 4'h4);
      repeat (10) @(posedge sys_clk);
      $display("test point done");
   endtask : t_point

   task automatic t_linear;
      wr(ADDR_SPEED, 32'h64);
      wr(ADDR_LIMIT, 32'hc8);
      lin(8'h34, ERR_NONE, 1'b0);
      hold_cfg <= 4'hf;
      rdy_cfg <= 4'h0;
      lin(8'h34, ERR_BUSY_M, 1'b0);
      hold_cfg <= 4'h2;
      lin(8'h34, ERR_BUSY_S, 1'b0);
      hold_cfg <= 4'h0;
      lin(8'h34, ERR_RDY_M, 1'b0);
      rdy_cfg <= 4'hd;
      lin(8'h34, ERR_RDY_S, 1'b0);
      rdy_cfg <= 4'hf;
      lin(8'h14, ERR_ASSIGN, 1'b0);
      wr(ADDR_SPEED, 32'hc9);
      lin(8'h34, ERR_SPEED, 1'b0);
      wr(ADDR_SPEED, 32'hc8);
      lin(8'h34, ERR_NONE, 1'b0);
      $display("test linear done");
   endtask : t_linear

   task automatic t_aux_origin;
      aux_req <= 4'hf;
      @(posedge sys_clk);
      aux_req <= 4'h0;
      lin(8'h34, ERR_AUX_M, 1'b0);
      wr(ADDR_CMD, cw(OP_AUX_CLR, 2'h0, 1'b0));
      #1 check("aux", aux_code_r, 4'he);
      lin(8'h34, ERR_AUX_S, 1'b0);
      wr(ADDR_CMD, cw(OP_AUX_CLR, 2'h1, 1'b0));
      lin(8'h34, ERR_NONE, 1'b0);
      lin(8'h74, ERR_ORG_M, 1'b0);
      wr(ADDR_CMD, cw(OP_FLOAT_ORG, 2'h0, 1'b0));
      lin(8'h74, ERR_ORG_S, 1'b0);
      home_req <= 4'h2;
      @(posedge sys_clk);
      home_req <= 4'h0;
      lin(8'h74, ERR_NONE, 1'b0);
      rd(ADDR_STATE, 32'hf3c0);
      $display("test aux origin done");
   endtask : t_aux_origin

   task automatic t_arc;
      wr(ADDR_SEG1_X, 32'h64);
      wr(ADDR_SEG1_Y, 32'h0);
      wr(ADDR_SEG2_X, 32'h0);
      wr(ADDR_SEG2_Y, 32'h64);
      wr(ADDR_ARC, 32'h65);
      lin(8'hb4, ERR_ARC_LONG, 1'b0);
      wr(ADDR_ARC, 32'h64);
      lin(8'hb4, ERR_NONE, 1'b1);
      wr(ADDR_SEG2_X, 32'h64);
      wr(ADDR_SEG2_Y, 32'h0);
      lin(8'hb4, ERR_ARC_SAME, 1'b0);
      wr(ADDR_ARC, 32'h0);
      lin(8'hb4, ERR_NONE, 1'b0);
      $display("test arc done");
   endtask : t_arc

   task automatic t_irq;
      wr(ADDR_IRQ_ST, 32'h7);
      wr(ADDR_IRQ_MSK, 32'h1);
      lin(8'h14, ERR_ASSIGN, 1'b0);
      #1 check("irq", irq_r, 1'b1);
      rd(ADDR_IRQ_ST, 32'h1);
      wr(ADDR_IRQ_ST, 32'h1);
      repeat (2) @(posedge sys_clk);
      #1 check("irq", irq_r, 1'b0);
      wr(ADDR_IRQ_MSK, 32'h0);
      aux_req <= 4'h1;
      @(posedge sys_clk);
      aux_req <= 4'h0;
      repeat (3) @(posedge sys_clk);
      #1 check("irq", irq_r, 1'b0);
      rd(ADDR_IRQ_ST, 32'h4);
      wr(ADDR_IRQ_MSK, 32'h4);
      repeat (2) @(posedge sys_clk);
      #1 check("irq", irq_r, 1'b1);
      $display("test irq done");
   endtask : t_irq

   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   // clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end

   // reset, then the scenarios in turn
   initial begin
      rst_n = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = '0;
      wr_data = '0;
      rdy_cfg = 4'hf;
      hold_cfg = 4'h0;
      home_req = 4'h0;
      aux_req = 4'h0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_point();
      t_linear();
      t_aux_origin();
      t_arc();
      t_irq();
      conclude();
   end
endmodule : tb_top
